// ==== rosc_consts.svh ====
// constants for the radio operating state controller
`ifndef ROSC_CONSTS_SVH
`define ROSC_CONSTS_SVH

// serial framing
`define ROSC_CMD_HEADER      8'h80
`define ROSC_FRAME_BITS      5'h10

// command codes
`define ROSC_CMD_TX          8'h60
`define ROSC_CMD_RX          8'h61
`define ROSC_CMD_READY       8'h62
`define ROSC_CMD_STANDBY     8'h63
`define ROSC_CMD_SLEEP       8'h64
`define ROSC_CMD_LOCK_RX     8'h65
`define ROSC_CMD_LOCK_TX     8'h66
`define ROSC_CMD_ABORT       8'h67
`define ROSC_CMD_WAKE_RELOAD 8'h68
`define ROSC_CMD_SOFT_RESET  8'h70

// reported state codes
`define ROSC_CODE_NONE       7'h00
`define ROSC_CODE_READY      7'h03
`define ROSC_CODE_LOCK       7'h0F
`define ROSC_CODE_RX         7'h33
`define ROSC_CODE_SLEEP      7'h36
`define ROSC_CODE_STANDBY    7'h40
`define ROSC_CODE_TX         7'h5F

// timing
`define ROSC_SYS_PERIOD_NS   40
`define ROSC_T_POWERUP_NS    650000
`define ROSC_T_LOCK_TMO_NS   80000
`define ROSC_POWERUP_CYCLES  (`ROSC_T_POWERUP_NS / `ROSC_SYS_PERIOD_NS)
`define ROSC_LOCK_TMO_CYCLES (`ROSC_T_LOCK_TMO_NS / `ROSC_SYS_PERIOD_NS)

`endif

// ==== rosc_pkg.sv ====
// types for the radio operating state controller
package rosc_pkg;

  // gray along shutdown, power-up, ready, lock, tx/rx, protocol
  typedef enum logic [3:0] {
    ST_SHUTDOWN = 4'h0,
    ST_POWERUP  = 4'h1,
    ST_READY    = 4'h3,
    ST_LOCK     = 4'h2,
    ST_TX       = 4'h6,
    ST_RX       = 4'h7,
    ST_PROTOCOL = 4'h5,
    ST_STANDBY  = 4'h4,
    ST_SLEEP    = 4'hC
  } rosc_state_t;

  typedef enum logic [1:0] {
    GOAL_NONE = 2'h0,
    GOAL_TX   = 2'h1,
    GOAL_RX   = 2'h2
  } rosc_goal_t;

  // packet engine events and routing options
  typedef struct packed {
    logic pkt_sent;
    logic tx_underflow;
    logic pkt_received;
    logic rx_timeout;
    logic rx_overflow;
    logic direct_mode;
    logic persist_tx;
    logic persist_rx;
    logic proto_tx_opt;
    logic proto_rx_opt;
    logic low_duty_cycle_mode;
    logic protocol_done;
  } rosc_radio_in_t;

  // serial frame state, cleared whenever chip select is high
  typedef struct packed {
    logic [4:0] bit_cnt;
    logic [7:0] shreg;
    logic       header_ok;
    logic       miso_oe;
  } rosc_frame_t;

  // last command word and its event toggle
  typedef struct packed {
    logic [7:0] code;
    logic       tgl;
  } rosc_link_cmd_t;

  typedef struct packed {
    logic        sdn_s1;
    logic        sdn_s2;
    logic        tg_s1;
    logic        tg_s2;
    logic        tg_s3;
    rosc_state_t state;
    rosc_goal_t  goal;
    rosc_goal_t  pending;
    logic [13:0] pu_cnt;
    logic [11:0] lock_cnt;
    logic [15:0] wake_cnt;
    logic [6:0]  state_code;
    logic        supply_on;
    logic        crystal_on;
    logic        synth_on;
    logic        wake_timer_on;
    logic        tx_active;
    logic        rx_active;
    logic        cmd_ready;
    logic        soft_reset;
    logic        wake_reload;
    logic        gpio_oe;
  } rosc_sys_t;

endpackage

// ==== rosc_top.sv ====
// radio operating state controller: serial command port and state machine
//
// Functional notes
// RULE1: shutdown pin high clears everything, serial and general pins float.
// RULE2: releasing shutdown brings the controller up in ready.
// RULE3: receive and transmit never switch directly; lock lies between.
// RULE4: one transmit or receive command sequences through lock automatically.
// RULE5: state code: ready 03, lock 0F, rx 33, sleep 36, standby 40, tx 5F.
// RULE6: ready, standby, lock entered by command hold until next command.
// RULE7: other states are timer bounded; ready/lock pass when transient.
// RULE8: standby and sleep keep data; only sleep keeps the wake timer.
// RULE9: shutdown to ready takes about 650 us; commands wait for it.
// RULE10: direction change by command needs abort and ready first.
// RULE11: wake from sleep with pending operation enters it without command.
// RULE12: lock is reached on lock detect or lock timeout, whichever first.
// RULE13: lock-for-receive or lock-for-transmit commands park in lock.
// RULE14: transmit ends on packet sent, direct underflow or abort.
// RULE15: after transmit: persistent tx, protocol handling, else ready.
// RULE16: receive ends on packet or timeout; direct mode on overflow/abort.
// RULE17: after receive: persist rx, protocol, low duty sleep, else ready.
// RULE18: abort accepted in tx or rx, then normal completion routing. The code skips the persistent tx/rx re-entry on abort.
// RULE19: host sends header 0x80 then command code, chip select may stay low.
// RULE20: transmit and receive commands start from ready only.
// RULE21: go-ready from standby, sleep, lock; standby and sleep from ready.
// RULE22: wake reload accepted anywhere, reloads wake timer from its settings. The code ignores it in shutdown and power-up.
// RULE23: a command acts once its byte completes, not at chip select release.
// RULE24: soft reset accepted anywhere, returns everything to defaults. The code ignores it in shutdown and power-up.
// RULE25: commands outside their permitted states are ignored.
`timescale 1ns/1ps
`include "rosc_consts.svh"

module rosc_top #(
  parameter int POWERUP_CYCLES = `ROSC_POWERUP_CYCLES
) (
  input  wire logic                    SYS_CLK,
  input  wire logic                    ARST_N,
  input  wire logic                    SHUTDOWN_PIN,
  input  wire logic                    SPI_CLK,
  input  wire logic                    SPI_CS_N,
  input  wire logic                    SPI_MOSI,
  output logic                         SPI_MISO_O,
  output logic                         SPI_MISO_OE,
  output logic                         GPIO_OE,
  input  wire logic                    LOCK_DETECT,
  input  wire rosc_pkg::rosc_radio_in_t RADIO_IN,
  input  wire logic [7:0]              WAKE_TIMER_PRESCALE,
  input  wire logic [7:0]              WAKE_TIMER_COUNT,
  output logic [6:0]                   STATE_CODE,
  output logic                         SUPPLY_ON,
  output logic                         CRYSTAL_ON,
  output logic                         SYNTH_ON,
  output logic                         WAKE_TIMER_ON,
  output logic                         TX_ACTIVE,
  output logic                         RX_ACTIVE,
  output logic                         CMD_READY,
  output logic                         SOFT_RESET,
  output logic                         WAKE_RELOAD
);

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // code reported for each internal state
  function automatic logic [6:0] state_code_of(rosc_pkg::rosc_state_t st);
    case (st)
      rosc_pkg::ST_READY    : state_code_of = `ROSC_CODE_READY;
      rosc_pkg::ST_PROTOCOL : state_code_of = `ROSC_CODE_READY;
      rosc_pkg::ST_LOCK     : state_code_of = `ROSC_CODE_LOCK;
      rosc_pkg::ST_RX       : state_code_of = `ROSC_CODE_RX;
      rosc_pkg::ST_SLEEP    : state_code_of = `ROSC_CODE_SLEEP;
      rosc_pkg::ST_STANDBY  : state_code_of = `ROSC_CODE_STANDBY;
      rosc_pkg::ST_TX       : state_code_of = `ROSC_CODE_TX;
      default               : state_code_of = `ROSC_CODE_NONE;
    endcase
  endfunction

  // active states keep crystal and synthesizer running
  function automatic logic synth_needed(rosc_pkg::rosc_state_t st);
    synth_needed = (st == rosc_pkg::ST_LOCK) || (st == rosc_pkg::ST_TX) ||
                   (st == rosc_pkg::ST_RX) || (st == rosc_pkg::ST_PROTOCOL);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // link domain: serial shift-in on the host's clock

  rosc_pkg::rosc_frame_t    frm;
  rosc_pkg::rosc_frame_t    next_frm;
  rosc_pkg::rosc_link_cmd_t lcmd;
  rosc_pkg::rosc_link_cmd_t next_lcmd;
  logic                     frame_rst_n;
  logic                     link_rst_n;

  // frame counters restart with each chip select; shutdown floats the port
  assign frame_rst_n = ARST_N & ~SPI_CS_N & ~SHUTDOWN_PIN; // RULE1
  assign link_rst_n  = ARST_N & ~SHUTDOWN_PIN;             // RULE1

  // header byte then command byte; later bytes of the frame are left alone
  always_comb
  begin
    next_frm  = frm;
    next_lcmd = lcmd;
    next_frm.miso_oe = 1'b1;
    if (frm.bit_cnt != `ROSC_FRAME_BITS)
    begin
      next_frm.bit_cnt = frm.bit_cnt + 5'h01;
      next_frm.shreg   = {frm.shreg[6:0], SPI_MOSI};
    end
    if (frm.bit_cnt == 5'h07)
      next_frm.header_ok =
        ({frm.shreg[6:0], SPI_MOSI} == `ROSC_CMD_HEADER); // RULE19
    // command word is latched on its last bit, no wait for chip select
    if (frm.bit_cnt == 5'h0F && frm.header_ok)
    begin
      next_lcmd.code = {frm.shreg[6:0], SPI_MOSI}; // RULE23
      next_lcmd.tgl  = ~lcmd.tgl;                  // RULE23
    end
  end

  always_ff @(posedge SPI_CLK or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      frm <= '0;
    else
      frm <= next_frm;
  end

  // command word survives chip select release until the next one
  always_ff @(posedge SPI_CLK or negedge link_rst_n)
  begin
    if (!link_rst_n)
      lcmd <= '0;
    else
      lcmd <= next_lcmd;
  end

  // the device only listens on this port, so the driven level is constant low
  assign SPI_MISO_O  = 1'b0;
  assign SPI_MISO_OE = frm.miso_oe;

  //////////////////////////////////////////////////////////////////////////////
  // system domain: main state machine

  rosc_pkg::rosc_sys_t s;
  rosc_pkg::rosc_sys_t next_s;
  logic                cmd_evt;
  logic [7:0]          cmd;
  logic                lock_reached;
  logic                tx_end;
  logic                rx_end;
  logic                wake_expired;
  logic                abort_active_command;
  logic [15:0]         wake_load;
  logic [16:0]         wake_prod;

  // toggle edge marks a new command; its word has been stable for cycles
  assign cmd_evt = s.tg_s2 ^ s.tg_s3;
  assign cmd     = lcmd.code;
  assign abort_active_command = cmd_evt && (cmd == `ROSC_CMD_ABORT);

  assign lock_reached = LOCK_DETECT ||
    (s.lock_cnt == 12'(`ROSC_LOCK_TMO_CYCLES - 1)); // RULE12

  // transmit ends on full packet, underflow in direct mode, or abort
  assign tx_end = RADIO_IN.pkt_sent ||
                  (RADIO_IN.direct_mode && RADIO_IN.tx_underflow) ||
                  abort_active_command; // RULE14 RULE18

  // packet mode ends on packet or timeout; direct mode on overflow or abort
  assign rx_end = RADIO_IN.direct_mode ?
                  (RADIO_IN.rx_overflow || abort_active_command) :
                  (RADIO_IN.pkt_received || RADIO_IN.rx_timeout ||
                   abort_active_command); // RULE16 RULE18

  // wake period is (prescale+1) x (count+1) ticks
  assign wake_prod = 17'((WAKE_TIMER_PRESCALE + 9'h001) *
                         (WAKE_TIMER_COUNT + 9'h001)); // RULE22
  // 256 x 256 overflows; saturate, a zero load would never expire
  assign wake_load = wake_prod[16] ? 16'hFFFF : wake_prod[15:0];
  assign wake_expired = (s.wake_cnt == 16'h0001);

  // next-state logic, commands and exits
  always_comb
  begin
    next_s = s;
    next_s.sdn_s1      = SHUTDOWN_PIN;
    next_s.sdn_s2      = s.sdn_s1;
    next_s.tg_s1       = lcmd.tgl;
    next_s.tg_s2       = s.tg_s1;
    next_s.tg_s3       = s.tg_s2;
    next_s.soft_reset  = 1'b0;
    next_s.wake_reload = 1'b0;
    if (s.state == rosc_pkg::ST_LOCK && s.lock_cnt != 12'hFFF)
      next_s.lock_cnt = s.lock_cnt + 12'h001;
    // wake timer only counts in sleep; standby leaves it stopped
    if (s.state == rosc_pkg::ST_SLEEP && s.wake_cnt != 16'h0000)
      next_s.wake_cnt = s.wake_cnt - 16'h0001; // RULE8

    case (s.state)
      rosc_pkg::ST_SHUTDOWN :
      begin
        next_s.pu_cnt = '0;
        next_s.state  = rosc_pkg::ST_POWERUP; // RULE2
      end
      // no command is honoured until the start-up delay has run out
      rosc_pkg::ST_POWERUP :
      begin
        next_s.pu_cnt = s.pu_cnt + 14'h0001;
        if (s.pu_cnt == 14'(POWERUP_CYCLES - 1))
          next_s.state = rosc_pkg::ST_READY; // RULE2 RULE9
      end
      rosc_pkg::ST_READY :
      begin
        if (cmd_evt)
        begin
          case (cmd)
            `ROSC_CMD_TX, `ROSC_CMD_RX, `ROSC_CMD_LOCK_RX, `ROSC_CMD_LOCK_TX :
            begin
              next_s.state    = rosc_pkg::ST_LOCK; // RULE3 RULE4 RULE20
              next_s.lock_cnt = '0;
              next_s.goal     = (cmd == `ROSC_CMD_TX) ? rosc_pkg::GOAL_TX :
                                (cmd == `ROSC_CMD_RX) ? rosc_pkg::GOAL_RX :
                                rosc_pkg::GOAL_NONE; // RULE13
            end
            `ROSC_CMD_STANDBY :
              next_s.state = rosc_pkg::ST_STANDBY; // RULE21
            `ROSC_CMD_SLEEP :
            begin
              next_s.state    = rosc_pkg::ST_SLEEP; // RULE21
              next_s.pending  = rosc_pkg::GOAL_NONE;
              next_s.wake_cnt = wake_load;
            end
            default :
              next_s.state = s.state; // RULE6 RULE25
          endcase
        end
      end
      // transient on the way to tx/rx, parked when entered by lock command
      rosc_pkg::ST_LOCK :
      begin
        if (lock_reached && s.goal == rosc_pkg::GOAL_TX)
          next_s.state = rosc_pkg::ST_TX; // RULE4 RULE7 RULE12
        else if (lock_reached && s.goal == rosc_pkg::GOAL_RX)
          next_s.state = rosc_pkg::ST_RX; // RULE4 RULE7 RULE12
        else if (cmd_evt && cmd == `ROSC_CMD_READY)
          next_s.state = rosc_pkg::ST_READY; // RULE13 RULE21
      end
      // tx routes to itself, protocol or ready; never straight to rx
      rosc_pkg::ST_TX :
      begin
        if (tx_end)
        begin
          if (RADIO_IN.persist_tx && !abort_active_command)
            next_s.state = rosc_pkg::ST_TX; // RULE15
          else if (RADIO_IN.proto_tx_opt)
            next_s.state = rosc_pkg::ST_PROTOCOL; // RULE15
          else
            next_s.state = rosc_pkg::ST_READY; // RULE3 RULE10 RULE15
        end
      end
      rosc_pkg::ST_RX :
      begin
        if (rx_end)
        begin
          if (RADIO_IN.persist_rx && !abort_active_command)
            next_s.state = rosc_pkg::ST_RX; // RULE17
          else if (RADIO_IN.proto_rx_opt)
            next_s.state = rosc_pkg::ST_PROTOCOL; // RULE17
          else if (RADIO_IN.low_duty_cycle_mode)
          begin
            next_s.state    = rosc_pkg::ST_SLEEP; // RULE17
            next_s.pending  = rosc_pkg::GOAL_RX;
            next_s.wake_cnt = wake_load;
          end
          else
            next_s.state = rosc_pkg::ST_READY; // RULE3 RULE10 RULE17
        end
      end
      // protocol engine owns the radio until it reports done
      rosc_pkg::ST_PROTOCOL :
      begin
        if (RADIO_IN.protocol_done)
          next_s.state = rosc_pkg::ST_READY; // RULE7
      end
      rosc_pkg::ST_STANDBY :
      begin
        if (cmd_evt && cmd == `ROSC_CMD_READY)
          next_s.state = rosc_pkg::ST_READY; // RULE6 RULE21
      end
      // wake-up resumes a pending operation through lock on its own
      rosc_pkg::ST_SLEEP :
      begin
        if (cmd_evt && cmd == `ROSC_CMD_READY)
          next_s.state = rosc_pkg::ST_READY; // RULE21
        else if (wake_expired && s.pending != rosc_pkg::GOAL_NONE)
        begin
          next_s.state    = rosc_pkg::ST_LOCK; // RULE11
          next_s.goal     = s.pending;         // RULE11
          next_s.lock_cnt = '0;
        end
        else if (wake_expired)
          next_s.state = rosc_pkg::ST_READY; // RULE7
      end
      default :
        next_s.state = rosc_pkg::ST_SHUTDOWN;
    endcase

    // reload is honoured in every state past power-up and restarts the period
    if (cmd_evt && cmd == `ROSC_CMD_WAKE_RELOAD &&
        s.state != rosc_pkg::ST_POWERUP && s.state != rosc_pkg::ST_SHUTDOWN)
    begin
      next_s.wake_reload = 1'b1;      // RULE22
      next_s.wake_cnt    = wake_load; // RULE22
    end

    // soft reset wins over everything except synchronised shutdown and restores defaults
    if (cmd_evt && cmd == `ROSC_CMD_SOFT_RESET &&
        s.state != rosc_pkg::ST_POWERUP && s.state != rosc_pkg::ST_SHUTDOWN)
    begin
      next_s.soft_reset = 1'b1;                  // RULE24
      next_s.state      = rosc_pkg::ST_READY;    // RULE24
      next_s.goal       = rosc_pkg::GOAL_NONE;
      next_s.pending    = rosc_pkg::GOAL_NONE;
      next_s.lock_cnt   = '0;
      next_s.wake_cnt   = '0;
    end

    // outputs registered from the state being entered
    next_s.state_code    = state_code_of(next_s.state); // RULE5
    next_s.supply_on     = (next_s.state != rosc_pkg::ST_SHUTDOWN);
    next_s.crystal_on    = (next_s.state == rosc_pkg::ST_READY) ||
                           synth_needed(next_s.state); // RULE8
    next_s.synth_on      = synth_needed(next_s.state); // RULE8
    next_s.wake_timer_on = (next_s.state == rosc_pkg::ST_SLEEP); // RULE8
    next_s.tx_active     = (next_s.state == rosc_pkg::ST_TX);
    next_s.rx_active     = (next_s.state == rosc_pkg::ST_RX);
    next_s.cmd_ready     = (next_s.state != rosc_pkg::ST_SHUTDOWN) &&
                           (next_s.state != rosc_pkg::ST_POWERUP); // RULE9
    next_s.gpio_oe       = next_s.cmd_ready;

    // synchronised shutdown drops all state; data is lost
    if (s.sdn_s2)
    begin
      next_s       = '0; // RULE1
      next_s.sdn_s1 = SHUTDOWN_PIN;
      next_s.sdn_s2 = s.sdn_s1;
      next_s.tg_s1  = lcmd.tgl;
      next_s.tg_s2  = s.tg_s1;
      next_s.tg_s3  = s.tg_s2;
      next_s.state  = rosc_pkg::ST_SHUTDOWN; // RULE1
    end
  end

  // a power-on reset behaves like a shutdown release
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      s <= '0;
    else
      s <= next_s;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign STATE_CODE    = s.state_code;
  assign SUPPLY_ON     = s.supply_on;
  assign CRYSTAL_ON    = s.crystal_on;
  assign SYNTH_ON      = s.synth_on;
  assign WAKE_TIMER_ON = s.wake_timer_on;
  assign TX_ACTIVE     = s.tx_active;
  assign RX_ACTIVE     = s.rx_active;
  assign CMD_READY     = s.cmd_ready;
  assign SOFT_RESET    = s.soft_reset;
  assign WAKE_RELOAD   = s.wake_reload;
  assign GPIO_OE       = s.gpio_oe; // RULE1

endmodule

// ==== rosc_assertions.sv ====
// port checker for the radio operating state controller
`timescale 1ns/1ps
module rosc_checker #(
  parameter int POWERUP_CYCLES = 20
) (
  input wire logic                     SYS_CLK,
  input wire logic                     ARST_N,
  input wire logic                     SHUTDOWN_PIN,
  input wire logic                     SPI_MISO_OE,
  input wire logic                     GPIO_OE,
  input wire rosc_pkg::rosc_radio_in_t RADIO_IN,
  input wire logic [6:0]               STATE_CODE,
  input wire logic                     SUPPLY_ON,
  input wire logic                     CRYSTAL_ON,
  input wire logic                     SYNTH_ON,
  input wire logic                     WAKE_TIMER_ON,
  input wire logic                     TX_ACTIVE,
  input wire logic                     RX_ACTIVE,
  input wire logic                     CMD_READY,
  input wire logic                     SOFT_RESET
);
  // sync plus power-up count plus output register
  localparam int PU_MAX = POWERUP_CYCLES + 8;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  //////////////////////////////////////////////////////////////////////////
  property p_code_ok;
    STATE_CODE inside {7'h00, 7'h03, 7'h0F, 7'h33, 7'h36, 7'h40, 7'h5F};
  endproperty
  a_code_ok: assert property (p_code_ok) else $error("bad code");
  property p_no_swap;
    (RX_ACTIVE |=> !TX_ACTIVE) and (TX_ACTIVE |=> !RX_ACTIVE);
  endproperty
  a_no_swap: assert property (p_no_swap) else $error("rx tx swap");
  property p_via_lock;
    $rose(TX_ACTIVE) || $rose(RX_ACTIVE) |-> $past(STATE_CODE) == 7'h0F;
  endproperty
  a_via_lock: assert property (p_via_lock) else $error("no lock");
  property p_shut_off;
    SHUTDOWN_PIN [*5] |-> STATE_CODE == 7'h00 && !SUPPLY_ON && !GPIO_OE
      && !SPI_MISO_OE;
  endproperty
  a_shut_off: assert property (p_shut_off) else $error("shut on");
  // powered but not ready; a hung start-up shows as a runaway count
  int dark_cnt;
  always_ff @(posedge SYS_CLK)
    dark_cnt <= (CMD_READY || SHUTDOWN_PIN || !ARST_N) ? 0 : dark_cnt + 1;
  // dark for a while after release, then ready within the bound
  sequence s_dark;
    (!CMD_READY) [*8];
  endsequence
  property p_wake;
    $fell(SHUTDOWN_PIN) |-> s_dark;
  endproperty
  a_wake: assert property (p_wake) else $error("wake early");
  property p_wake_time;
    (dark_cnt <= PU_MAX) and ($rose(CMD_READY) |-> STATE_CODE == 7'h03);
  endproperty
  a_wake_time: assert property (p_wake_time) else $error("wake time");
  property p_low_pwr;
    (STATE_CODE == 7'h40 |-> SUPPLY_ON && !CRYSTAL_ON && !SYNTH_ON
      && !WAKE_TIMER_ON) and (STATE_CODE == 7'h36 |-> WAKE_TIMER_ON
      && !CRYSTAL_ON && !SYNTH_ON);
  endproperty
  a_low_pwr: assert property (p_low_pwr) else $error("low power");
  property p_tx_end;
    TX_ACTIVE && RADIO_IN.pkt_sent |=> TX_ACTIVE == $past(RADIO_IN.persist_tx);
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("tx end");
  property p_rx_end;
    RX_ACTIVE && (RADIO_IN.pkt_received || RADIO_IN.rx_timeout)
      && !RADIO_IN.direct_mode && !RADIO_IN.persist_rx
      && !RADIO_IN.proto_rx_opt
      |=> STATE_CODE == ($past(RADIO_IN.low_duty_cycle_mode) ? 7'h36 : 7'h03);
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("rx end");
  property p_direct;
    RX_ACTIVE && RADIO_IN.direct_mode && RADIO_IN.pkt_received
      && !RADIO_IN.rx_overflow |=> RX_ACTIVE;
  endproperty
  a_direct: assert property (p_direct) else $error("direct rx");
  property p_srst;
    SOFT_RESET |-> ##[0:2] STATE_CODE == 7'h03;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset");
endmodule
bind rosc_top rosc_checker #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_chk (.*);

// ==== rosc_host_model.sv ====
// host side model: command frames on the serial port
`timescale 1ns/1ps
module rosc_host_model (
  output logic SPI_CLK,
  output logic SPI_CS_N,
  output logic SPI_MOSI
);
  // idle: deselected, clock parked low between frames
  initial
  begin
    SPI_CLK = 1'b0;
    SPI_CS_N = 1'b1;
    SPI_MOSI = 1'b0;
  end
  // header then code, msb first, 30 ns bit clock
  task automatic send(input logic [7:0] hdr, input logic [7:0] cmd);
    logic [15:0] w;
    w = {hdr, cmd};
    #7 SPI_CS_N = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      SPI_MOSI = w[i];
      #15 SPI_CLK = 1'b1;
      #15 SPI_CLK = 1'b0;
    end
    #15 SPI_CS_N = 1'b1;
    // no pull on the line, so the released value moves
    SPI_MOSI = ~SPI_MOSI;
    // keeps the gap between commands above 8 system cycles
    #400;
  endtask
endmodule

// ==== test_radio_operating_state_controller.sv ====
// self-checking bench for the radio operating state controller
`timescale 1ns/1ps
module test_radio_operating_state_controller;
  localparam int PU = 20;
  logic clk, arst_n, shutdown_pin, sck, cs_n, mosi, miso, miso_oe, gpio_oe, lk;
  logic supply, xtal, synth, wk_on, tx_on, rx_on, rdy, srst, wrel;
  logic [7:0]               wk_pre;
  logic [7:0]               wk_cnt;
  logic [6:0]               code;
  logic [6:0]               e;
  logic                     t, p, l, r, dm, ev;
  rosc_pkg::rosc_radio_in_t radio;
  int                       err_count, compares, strobes;
  integer                   seed;
  rosc_top #(.POWERUP_CYCLES(PU)) DUT (
    .SYS_CLK(clk), .ARST_N(arst_n), .SHUTDOWN_PIN(shutdown_pin), .SPI_CLK(sck),
    .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO_O(miso),
    .SPI_MISO_OE(miso_oe), .GPIO_OE(gpio_oe), .LOCK_DETECT(lk),
    .RADIO_IN(radio), .WAKE_TIMER_PRESCALE(wk_pre),
    .WAKE_TIMER_COUNT(wk_cnt), .STATE_CODE(code), .SUPPLY_ON(supply),
    .CRYSTAL_ON(xtal), .SYNTH_ON(synth), .WAKE_TIMER_ON(wk_on),
    .TX_ACTIVE(tx_on), .RX_ACTIVE(rx_on), .CMD_READY(rdy),
    .SOFT_RESET(srst), .WAKE_RELOAD(wrel));
  rosc_host_model u_host (.SPI_CLK(sck), .SPI_CS_N(cs_n), .SPI_MOSI(mosi));
  //////////////////////////////////////////////////////////////////////////
  // 25 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // strobes stand one cycle, so each falling edge sees one at most
  always @(negedge clk)
    strobes += wrel + srst;
  task automatic give_verdict;
    $display("TB: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_code(input string n, input logic [6:0] x,
                          input logic [6:0] g);
    compares++;
    if (g !== x)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic x, input logic g);
    compares++;
    if (g !== x)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %b got %b", n, x, g);
    end
  endtask
  // bounded wait for a state code; running out ends the run
  task automatic wait_code(input logic [6:0] x, input int lim);
    for (int n = 0; n < lim && code !== x; n++)
      @(negedge clk);
    chk_code("state code", x, code);
    if (code !== x)
      give_verdict();
  endtask
  // ignored commands: code must not move over the answer latency
  task automatic stay(input logic [6:0] x);
    repeat (12) @(negedge clk);
    chk_code("held code", x, code);
  endtask
  task automatic cmd(input logic [7:0] c);
    u_host.send(8'h80, c);
    @(negedge clk);
  endtask
  // mask bits: 800 sent, 400 underflow, 200 received, 100 timeout,
  // 080 overflow, 001 protocol done
  task automatic pulse(input logic [11:0] m);
    @(negedge clk);
    radio = radio | m;
    @(negedge clk);
    radio = radio & ~m;
    @(negedge clk);
  endtask
  function automatic logic [6:0] dest(input logic a, b, c, d);
    if (b)
      return a ? 7'h5F : 7'h33;
    if (d || a || !c)
      return 7'h03;
    return 7'h36;
  endfunction
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h4082;
    err_count = 0;
    compares = 0;
    {arst_n, shutdown_pin, lk} = 3'h0;
    radio = '0;
    wk_pre = 8'h07;
    wk_cnt = 8'h07;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    wait_code(7'h03, PU + 20);
    chk_bit("cmd ready", 1'b1, rdy);
    chk_bit("gpio enable", 1'b1, gpio_oe);
    // stable standby, reload in standby, refused codes
    cmd(8'h63);
    wait_code(7'h40, 20);
    cmd(8'h68);
    stay(7'h40);
    chk_code("strobes", 7'h01, 7'(strobes));
    cmd(8'h64);
    stay(7'h40);
    cmd(8'h62);
    wait_code(7'h03, 20);
    cmd(8'h67);
    stay(7'h03);
    u_host.send(8'h81, 8'h63);
    stay(7'h03);
    // parked lock ignores detect and timeout
    for (int k = 0; k < 2; k++)
    begin
      cmd(k ? 8'h66 : 8'h65);
      wait_code(7'h0F, 20);
      lk = 1'b1;
      repeat (2100) @(negedge clk);
      chk_code("parked lock", 7'h0F, code);
      lk = 1'b0;
      cmd(8'h62);
      wait_code(7'h03, 20);
    end
    cmd(8'h64);
    wait_code(7'h36, 20);
    wait_code(7'h03, 100);
    $display("TB: stable states done");
    // random transfers with random routing options
    for (int i = 0; i < 8; i++)
    begin
      t = i[0];
      {p, l, r, dm, ev} = 5'($random(seed));
      // level options only; event bits idle low
      radio = {5'h00, dm, p, p, r, r, l, 1'b0};
      lk = 1'b0;
      cmd(t ? 8'h60 : 8'h61);
      wait_code(7'h0F, 20);
      if (ev)
      begin
        repeat ($unsigned($random(seed)) % 40) @(negedge clk);
        lk = 1'b1;
      end
      wait_code(t ? 7'h5F : 7'h33, 2100);
      lk = 1'b0;
      cmd(t ? 8'h61 : 8'h60);
      stay(t ? 7'h5F : 7'h33);
      if (dm && !t)
      begin
        pulse(12'h200);
        stay(7'h33);
      end
      pulse(t ? (dm ? 12'h400 : 12'h800) : (dm ? 12'h080 : 12'h300));
      e = dest(t, p, l, r);
      wait_code(e, 10);
      if (p)
      begin
        cmd(8'h67);
        e = dest(t, 1'b0, l, r);
        wait_code(e, 20);
      end
      if (e == 7'h36)
      begin
        wait_code(7'h0F, 100);
        lk = 1'b1;
        wait_code(7'h33, 10);
        radio.low_duty_cycle_mode = 1'b0;
        cmd(8'h67);
        wait_code(7'h03, 20);
      end
      if (r)
        pulse(12'h001);
      $display("TB: transfer %0d done", i);
    end
    // soft reset out of transmit
    radio = '0;
    lk = 1'b1;
    cmd(8'h60);
    wait_code(7'h5F, 20);
    cmd(8'h70);
    wait_code(7'h03, 20);
    chk_code("strobes", 7'h02, 7'(strobes));
    // shutdown pin and release
    shutdown_pin = 1'b1;
    repeat (10) @(negedge clk);
    chk_code("shutdown code", 7'h00, code);
    chk_bit("supply", 1'b0, supply);
    chk_bit("miso enable", 1'b0, miso_oe);
    shutdown_pin = 1'b0;
    wait_code(7'h03, PU + 20);
    $display("TB: reset and shutdown done");
    give_verdict();
  end
endmodule
